// ### verilog/ett_defines.svh
// Constants for the event timer and receive guard configuration block
`ifndef ETT_DEFINES_SVH
`define ETT_DEFINES_SVH

// Register bus geometry
`define ETT_ADDR_W 8
`define ETT_DATA_W 32

// Register offsets
`define ETT_OFS_TMR_CFG 8'h10
`define ETT_OFS_RXW_CFG 8'h11
`define ETT_OFS_PRESET 8'h20
`define ETT_OFS_COUNT 8'h21
`define ETT_OFS_STATUS 8'h22

// Timer configuration field positions
`define ETT_B_HALT_RX_BEGIN 20
`define ETT_B_HALT_TX_BEGIN 19
`define ETT_B_HALT_OUT_ON 18
`define ETT_B_HALT_OUT_OFF 17
`define ETT_B_HALT_OWN_ON 16
`define ETT_B_HALT_OWN_OFF 15
`define ETT_B_LAUNCH_RX_BEGIN 14
`define ETT_B_LAUNCH_RX_END 13
`define ETT_B_LAUNCH_TX_BEGIN 12
`define ETT_B_LAUNCH_TX_END 11
`define ETT_B_LAUNCH_OUT_ON 10
`define ETT_B_LAUNCH_OUT_OFF 9
`define ETT_B_LAUNCH_OWN_ON 8
`define ETT_B_LAUNCH_OWN_OFF 7
`define ETT_B_LAUNCH_NOW 6
`define ETT_F_RATE_HI 5
`define ETT_F_RATE_LO 3
`define ETT_B_CLK_SRC 2
`define ETT_B_RELOAD 1
`define ETT_B_ENABLE 0
`define ETT_TMR_CFG_W 21

// Receive wait configuration fields
`define ETT_F_RXW_VAL_HI 27
`define ETT_F_RXW_VAL_LO 8
`define ETT_F_RXW_PRE_HI 7
`define ETT_F_RXW_PRE_LO 0
`define ETT_RXW_CFG_W 28
`define ETT_RXW_VAL_W 20
`define ETT_RXW_PRE_W 8

// Reset values
`define ETT_RST_TMR_CFG 21'h000000
`define ETT_RST_RXW_CFG 28'h0000000
`define ETT_RST_PRESET 20'h00000

// Event timer counter width
`define ETT_TMR_W 20

// Frontend clock synthesis from the system clock
`define ETT_SYS_HZ 64'd125000000
`define ETT_FRONTEND_HZ 64'd13560000
`define ETT_NCO_W 24
`define ETT_NCO_INC ((`ETT_FRONTEND_HZ << `ETT_NCO_W) / `ETT_SYS_HZ)

// Prescaler divider width and full mask
`define ETT_DIV_W 8
`define ETT_RATE_W 3
`define ETT_RATE_MAX 3'h7
`define ETT_MASK_ALL 9'h0ff

// Sticky expiry bit of the status register
`define ETT_B_STS_EXPIRED 1

`endif

// ### verilog/ett_pkg.sv
// Types shared by the event timer block
`default_nettype none
`include "ett_defines.svh"
package ett_pkg;
    // Frame events from the frontend logic, one-cycle pulses
    typedef struct packed {
        logic rx_begin;  // First bit of an incoming frame
        logic rx_nibble; // First four bits of an incoming frame in
        logic rx_end;    // Incoming frame finished
        logic tx_begin;  // Outgoing frame starts
        logic tx_end;    // Outgoing frame finished
    } ett_frame_ev_type;

    // Receive guard timer settings handed to the receiver
    typedef struct packed {
        logic [`ETT_RXW_VAL_W-1:0] reload;   // Guard timer reload value
        logic [`ETT_RXW_PRE_W-1:0] prescale; // Guard prescaler reload value
        logic enable;                        // Guard time active
    } ett_guard_cfg_type;

    // Timer run state, Gray coded
    typedef enum logic [1:0] {
        ETT_IDLE = 2'b00,
        ETT_RUN = 2'b01
    } ett_state_type;
endpackage

`default_nettype wire

// ### verilog/ett_timer.sv
// Event triggered countdown timer and receive guard configuration
// Register map
// 0x10 timer configuration, bits 20 to 0
// 0x11 receive wait configuration, bits 27 to 0
// 0x20 timer preset, bits 19 to 0
// 0x21 live count, read only
// 0x22 status: bit 0 running, bit 1 expired
// Expired bit is sticky; writing one clears it
// Unmapped addresses read zero, writes dropped
//
// Register bus timing
// Writes land on the strobe edge itself
// Read data registered, valid for one cycle
// Read data is zero in every other cycle
// Strobes may follow each other with no gap
// No wait states on either access
//
// Timer flow
// Idle until a launch source fires
// Launch loads the preset and starts counting
// Launch while running restarts from the preset
// Launch with a zero preset stays idle
// Halt freezes the count where it stands
// Halt beats launch in the same cycle
// Clearing enable freezes the count as well
// Enable written with a launch acts at once
// Expiry pulse follows the last tick by one cycle
// Sticky expired bit set wins over its clear
//
// Timer clock
// Frontend ticks come from a phase accumulator
// Roughly 13.56 ticks per 125 system cycles
// Tick spacing is 9 or 10 system cycles
// Prescaler divides frontend ticks by powers of two
// Rate code 0 divides by 2, code 7 by 256
// Divider runs free, so the first tick wanders
// Software must not rely on first-tick phase
//
// Radio events
// Frame events are one-cycle pulses, same clock
// Field levels are asynchronous, synchronised here
// Field edges act three cycles after the pin moves
// Field glitches under one cycle may be missed
// Nibble event marks four received bits
// Extra receive delay is the frontend's concern
//
// Receive guard settings
// Reload and prescaler passed straight through
// Guard enable follows a nonzero reload
// Prescaler value is software's duty, not checked
//
// Limits
// Count and preset are 20 bits wide
// Expiry leaves only as a pulse and a sticky bit
// No interrupt logic in this block
// Preset changes act at the next launch or reload
// Configuration changes act from the next cycle, except enable and launch-now, which act at once
// Halt keeps the count; a later launch restarts it
// Both edge settings of one field may be on at once
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "ett_defines.svh"

module ett_timer (
    input wire logic clk_i,                          // System clock, 125 MHz
    input wire logic sys_rst_i,                      // Synchronous reset, active high
    input wire logic [`ETT_ADDR_W-1:0] addr_i,       // Register address
    input wire logic [`ETT_DATA_W-1:0] wdata_i,      // Register write data
    input wire logic wr_i,                           // Write strobe
    input wire logic rd_i,                           // Read strobe
    output logic [`ETT_DATA_W-1:0] rdata_o,          // Read data, cycle after strobe
    input wire ett_pkg::ett_frame_ev_type frame_ev_i, // Frame event pulses
    input wire logic outside_field_i,                // Outside field detected, async
    input wire logic own_field_i,                    // Own field switched on, async
    output logic [`ETT_TMR_W-1:0] count_o,           // Current count
    output logic running_o,                          // Timer counting
    output logic expired_o,                          // One-cycle expiry pulse
    output ett_pkg::ett_guard_cfg_type guard_cfg_o   // Guard timer settings
);
    import ett_pkg::*;

    // Rate mask: low bits of the divider that must be all ones for a tick
    // Code 0 gives one bit, code 7 gives eight bits
    // Shifting one all-ones mask keeps this a single expression
    function automatic logic [`ETT_DIV_W-1:0] rate_mask(input logic [`ETT_RATE_W-1:0] sel);
        logic [8:0] full;
        full = `ETT_MASK_ALL >> (`ETT_RATE_MAX - sel);
        return full[`ETT_DIV_W-1:0];
    endfunction

    // Rising and falling edge of a level against its previous value
    function automatic logic [1:0] edges(input logic now, input logic prev);
        return {now & ~prev, ~now & prev};
    endfunction

    // Configuration registers
    logic [`ETT_TMR_CFG_W-1:0] tmr_cfg;      // Event timer configuration
    logic [`ETT_RXW_CFG_W-1:0] rxw_cfg;      // Receive wait configuration
    logic [`ETT_TMR_W-1:0] preset;           // Timer preset value
    logic [`ETT_DATA_W-1:0] rdata;           // Registered read data

    // Timer state
    ett_state_type state;                    // Run state
    ett_state_type next_state;               // Next run state
    logic [`ETT_TMR_W-1:0] count;            // Down counter
    logic [`ETT_TMR_W-1:0] next_count;       // Next counter value
    logic expired;                           // Registered expiry pulse
    logic expired_seen;                      // Sticky expiry for status

    // Frontend clock synthesis and prescaler
    logic [`ETT_NCO_W-1:0] nco_acc;          // Phase accumulator
    logic [`ETT_NCO_W:0] nco_sum;            // Accumulator plus increment
    logic frontend_tick; // 13.56 MHz enable pulse
    logic [`ETT_DIV_W-1:0] div_cnt;          // Free divider of frontend ticks
    logic pre_tick;                          // Prescaled enable pulse
    logic tmr_tick;                          // Selected timer enable

    // Field level synchronisers and history
    logic out_meta;                          // Outside field, first stage
    logic out_sync;                          // Outside field, second stage
    logic out_prev;                          // Outside field, previous value
    logic own_meta;                          // Own field, first stage
    logic own_sync;                          // Own field, second stage
    logic own_prev;                          // Own field, previous value

    // Decoded register accesses
    wire sel_tmr = (addr_i == `ETT_OFS_TMR_CFG);
    wire sel_rxw = (addr_i == `ETT_OFS_RXW_CFG);
    wire sel_pre = (addr_i == `ETT_OFS_PRESET);
    wire sel_cnt = (addr_i == `ETT_OFS_COUNT);
    wire sel_sts = (addr_i == `ETT_OFS_STATUS);
    wire wr_tmr = wr_i & sel_tmr;
    wire wr_rxw = wr_i & sel_rxw;
    wire wr_pre = wr_i & sel_pre;

    // Configuration fields
    wire enable = tmr_cfg[`ETT_B_ENABLE];
    wire reload_on = tmr_cfg[`ETT_B_RELOAD];
    wire clk_src = tmr_cfg[`ETT_B_CLK_SRC];
    wire [`ETT_RATE_W-1:0] rate_sel = tmr_cfg[`ETT_F_RATE_HI:`ETT_F_RATE_LO];

    // Field edges
    wire [1:0] out_edge = edges(out_sync, out_prev);
    wire [1:0] own_edge = edges(own_sync, own_prev);

    // Halt sources gated by their enables
    wire halt_rx = tmr_cfg[`ETT_B_HALT_RX_BEGIN] & frame_ev_i.rx_nibble;
    wire halt_tx = tmr_cfg[`ETT_B_HALT_TX_BEGIN] & frame_ev_i.tx_begin;
    wire halt_out = (tmr_cfg[`ETT_B_HALT_OUT_ON] & out_edge[1])
                  | (tmr_cfg[`ETT_B_HALT_OUT_OFF] & out_edge[0]);
    wire halt_own = (tmr_cfg[`ETT_B_HALT_OWN_ON] & own_edge[1])
                  | (tmr_cfg[`ETT_B_HALT_OWN_OFF] & own_edge[0]);
    wire halt_trigger = halt_rx | halt_tx | halt_out | halt_own;

    // Launch sources gated by their enables
    wire launch_rx = (tmr_cfg[`ETT_B_LAUNCH_RX_BEGIN] & frame_ev_i.rx_begin)
                   | (tmr_cfg[`ETT_B_LAUNCH_RX_END] & frame_ev_i.rx_end);
    wire launch_tx = (tmr_cfg[`ETT_B_LAUNCH_TX_BEGIN] & frame_ev_i.tx_begin)
                   | (tmr_cfg[`ETT_B_LAUNCH_TX_END] & frame_ev_i.tx_end);
    wire launch_out = (tmr_cfg[`ETT_B_LAUNCH_OUT_ON] & out_edge[1])
                    | (tmr_cfg[`ETT_B_LAUNCH_OUT_OFF] & out_edge[0]);
    wire launch_own = (tmr_cfg[`ETT_B_LAUNCH_OWN_ON] & own_edge[1])
                    | (tmr_cfg[`ETT_B_LAUNCH_OWN_OFF] & own_edge[0]);
    // Immediate start on a write that sets the start bit
    wire launch_now = wr_tmr & wdata_i[`ETT_B_LAUNCH_NOW];
    wire launch_trigger = launch_rx | launch_tx | launch_out | launch_own | launch_now;

    // Enable as it stands after this cycle's write, so a write
    // That sets enable and launch together starts at once
    // Without it the first launch after enabling would be lost
    wire enable_now = wr_tmr ? wdata_i[`ETT_B_ENABLE] : enable;

    // Frontend tick from the accumulator carry
    // One pulse per frontend clock period on average
    assign nco_sum = {1'b0, nco_acc} + {1'b0, `ETT_NCO_W'(`ETT_NCO_INC)};
    assign frontend_tick = nco_sum[`ETT_NCO_W];

    // Prescaled tick: divide frontend ticks by 2 to 256
    // Tick when the masked divider bits are all ones,
    // So each rate is a power-of-two share of the ticks
    assign pre_tick = frontend_tick & ((div_cnt & rate_mask(rate_sel)) == rate_mask(rate_sel));

    // Timer clock source selection
    // Switching source mid-count is safe, as both
    // Sources are enables on the same clock
    assign tmr_tick = clk_src ? pre_tick : frontend_tick;

    // Priority inside one cycle, highest first
    // Order: disable, halt, launch, running tick
    // A halt on the last tick suppresses expiry
    // A launch on the last tick restarts, with no pulse
    // Reload with a zero preset falls back to idle
    // The count never wraps below zero
    // Countdown and expiry, halt wins over launch in one cycle
    wire at_one = (count == `ETT_TMR_W'(1));
    wire run_tick = (state == ETT_RUN) & tmr_tick;
    wire expire_now = run_tick & at_one & ~halt_trigger & ~launch_trigger & enable_now;

    // Next state and count
    always_comb begin
        next_state = state;
        next_count = count;
        if (!enable_now) begin
            // Disabled: counter frozen, nothing runs
            next_state = ETT_IDLE;
        end else if (halt_trigger) begin
            // Halt event freezes the count
            next_state = ETT_IDLE;
        end else if (launch_trigger) begin
            // Launch loads the preset
            next_count = preset;
            next_state = (preset == `ETT_TMR_W'(0)) ? ETT_IDLE : ETT_RUN;
        end else if (run_tick) begin
            unique case (1'b1)
                // Expiry with reload: restart at preset without a gap
                at_one & reload_on: begin
                    next_count = preset;
                    next_state = (preset == `ETT_TMR_W'(0)) ? ETT_IDLE : ETT_RUN;
                end
                // Expiry without reload: stop at zero
                at_one & ~reload_on: begin
                    next_count = `ETT_TMR_W'(0);
                    next_state = ETT_IDLE;
                end
                // Ordinary decrement
                default: begin
                    next_count = count - `ETT_TMR_W'(1);
                end
            endcase
        end
    end

    // Clock synthesis and divider
    // The increment is rounded down, so the frontend
    // Rate runs a hair slow of its nominal value
    // The divider counts frontend ticks only
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            nco_acc <= '0;
            div_cnt <= '0;
        end else begin
            nco_acc <= nco_sum[`ETT_NCO_W-1:0];
            if (frontend_tick) begin
                div_cnt <= div_cnt + `ETT_DIV_W'(1);
            end
        end
    end

    // Field synchronisers and edge history
    // Two stages per pin before any logic reads it
    // Only the second stage feeds the history stage
    // A field present at reset release shows as a rising edge
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            out_meta <= 1'b0;
            out_sync <= 1'b0;
            out_prev <= 1'b0;
            own_meta <= 1'b0;
            own_sync <= 1'b0;
            own_prev <= 1'b0;
        end else begin
            out_meta <= outside_field_i;
            out_sync <= out_meta;
            out_prev <= out_sync;
            own_meta <= own_field_i;
            own_sync <= own_meta;
            own_prev <= own_sync;
        end
    end

    // Timer state and counter
    // Count and state move together on one edge,
    // So the outputs never show a half-updated timer
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= ETT_IDLE;
            count <= '0;
            expired <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            expired <= expire_now;
        end
    end

    // Sticky expiry, set wins over a status write clearing it
    // An expiry racing the clear is never lost
    // Writing zero to the bit leaves it alone
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            expired_seen <= 1'b0;
        end else if (expire_now) begin
            expired_seen <= 1'b1;
        end else if (wr_i & sel_sts & wdata_i[`ETT_B_STS_EXPIRED]) begin
            expired_seen <= 1'b0;
        end
    end

    // Configuration register writes
    // Only the used bits are stored; the rest read zero
    // The launch-now bit is stored and reads back
    // Its launch acts only in the writing cycle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tmr_cfg <= `ETT_RST_TMR_CFG;
            rxw_cfg <= `ETT_RST_RXW_CFG;
            preset <= `ETT_RST_PRESET;
        end else begin
            if (wr_tmr) begin
                tmr_cfg <= wdata_i[`ETT_TMR_CFG_W-1:0];
            end
            if (wr_rxw) begin
                rxw_cfg <= wdata_i[`ETT_RXW_CFG_W-1:0];
            end
            if (wr_pre) begin
                preset <= wdata_i[`ETT_TMR_W-1:0];
            end
        end
    end

    // Read mux, unmapped addresses read zero
    // Status packs running in bit 0, expired in bit 1
    // Count reads the live value of the strobe cycle
    wire [`ETT_DATA_W-1:0] read_mux =
        sel_tmr ? `ETT_DATA_W'(tmr_cfg) :
        sel_rxw ? `ETT_DATA_W'(rxw_cfg) :
        sel_pre ? `ETT_DATA_W'(preset) :
        sel_cnt ? `ETT_DATA_W'(count) :
        sel_sts ? `ETT_DATA_W'({expired_seen, state == ETT_RUN}) :
        '0;

    // Read data registered, valid only the cycle after the strobe
    // Cleared otherwise so a stale word never lingers
    // On the bus between reads
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata <= '0;
        end else if (rd_i) begin
            rdata <= read_mux;
        end else begin
            rdata <= '0;
        end
    end

    // Outputs
    assign rdata_o = rdata;
    assign count_o = count;
    assign running_o = (state == ETT_RUN);
    assign expired_o = expired;

    // Guard settings packed as one word with a single driver
    wire [`ETT_RXW_VAL_W-1:0] guard_reload = rxw_cfg[`ETT_F_RXW_VAL_HI:`ETT_F_RXW_VAL_LO];
    wire [`ETT_RXW_PRE_W-1:0] guard_pre = rxw_cfg[`ETT_F_RXW_PRE_HI:`ETT_F_RXW_PRE_LO];
    wire guard_on = (guard_reload != `ETT_RXW_VAL_W'(0));
    assign guard_cfg_o = {guard_reload, guard_pre, guard_on};
endmodule

`default_nettype wire

// ### sim/ett_timer_props.sv
// Port checker for the event timer block
`timescale 1ns/10ps
`default_nettype none
`include "ett_defines.svh"
module ett_timer_props (
    input wire logic clk_i,                          // Clock
    input wire logic sys_rst_i,                      // Reset
    input wire logic [7:0] addr_i,                   // Address
    input wire logic [31:0] wdata_i,                 // Write data
    input wire logic wr_i,                           // Write strobe
    input wire logic rd_i,                           // Read strobe
    input wire logic [31:0] rdata_o,                 // Read data
    input wire ett_pkg::ett_frame_ev_type frame_ev_i, // Frame events
    input wire logic outside_field_i,                // Outside field
    input wire logic own_field_i,                    // Own field
    input wire logic [19:0] count_o,                 // Count
    input wire logic running_o,                      // Running
    input wire logic expired_o,                      // Expiry pulse
    input wire ett_pkg::ett_guard_cfg_type guard_cfg_o // Guard settings
);
    import ett_pkg::*;
    logic [20:0] cfg; // Shadow of timer configuration
    wire logic cfg_wr = wr_i && addr_i == `ETT_OFS_TMR_CFG; // Config write
    // Track configuration writes
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg <= '0;
        end else if (cfg_wr) begin
            cfg <= wdata_i[20:0];
        end
    end
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    chk_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data not zero outside read");
    chk_guard_enable: assert property (
        wr_i && addr_i == `ETT_OFS_RXW_CFG
        |=> guard_cfg_o.enable == ($past(wdata_i[27:8]) != 20'h0))
        else $error("guard enable wrong");
    chk_guard_fields: assert property (
        wr_i && addr_i == `ETT_OFS_RXW_CFG |=> guard_cfg_o.reload == $past(wdata_i[27:8])
        && guard_cfg_o.prescale == $past(wdata_i[7:0]))
        else $error("guard fields wrong");
    chk_halt_nibble: assert property (
        cfg[20] && frame_ev_i.rx_nibble && !cfg_wr |=> !running_o)
        else $error("no halt on receive nibble");
    chk_halt_transmit: assert property (
        cfg[19] && frame_ev_i.tx_begin && !cfg_wr |=> !running_o)
        else $error("no halt on transmit begin");
    chk_launch_receive: assert property (
        cfg[0] && cfg[14] && cfg[20:15] == 6'h0 && frame_ev_i.rx_begin && !cfg_wr
        |=> running_o || count_o == 20'h0)
        else $error("no launch on receive begin");
    chk_disabled_idle: assert property (
        !cfg[0] && !cfg_wr |=> !running_o && $stable(count_o))
        else $error("timer active while disabled");
    chk_stop_zero: assert property (
        expired_o && !cfg[1] |-> count_o == 20'h0 && !running_o && $past(count_o) == 20'h1)
        else $error("expiry without stop at zero");
    chk_reload_run: assert property (
        expired_o && cfg[1] && cfg[0] |-> running_o)
        else $error("reload did not keep running");
endmodule
bind ett_timer ett_timer_props chk_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .frame_ev_i(frame_ev_i), .outside_field_i(outside_field_i),
    .own_field_i(own_field_i), .count_o(count_o), .running_o(running_o),
    .expired_o(expired_o), .guard_cfg_o(guard_cfg_o));
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the event timer block
`timescale 1ns/10ps
`default_nettype none
`include "ett_defines.svh"
module tb_top;
    import ett_pkg::*;
    logic clk_i = 1'b0; // Clock
    logic sys_rst_i = 1'b1; // Reset
    logic [7:0] addr_i = 8'h0; // Address
    logic [31:0] wdata_i = 32'h0; // Write data
    logic wr_i = 1'b0; // Write strobe
    logic rd_i = 1'b0; // Read strobe
    ett_frame_ev_type frame_ev_i = '0; // Frame events
    logic outside_field_i = 1'b0; // Outside field
    logic own_field_i = 1'b0; // Own field
    logic [31:0] rdata_o; // Read data
    logic [19:0] count_o; // Count
    logic running_o; // Running
    logic expired_o; // Expiry pulse
    ett_guard_cfg_type guard_cfg_o; // Guard settings
    int errors = 0; // Mismatches
    int tests_run = 0; // Comparisons
    logic [31:0] rd_val; // Last read word
    // Event table: launch entries first, then halt entries
    localparam logic [20:0] EVC [14] = '{21'h004000, 21'h002000, 21'h001000, 21'h000800,
        21'h000400, 21'h000200, 21'h000100, 21'h000080, 21'h100040, 21'h080040,
        21'h040040, 21'h020040, 21'h010040, 21'h008040};
    localparam logic [4:0] EVE [14] = '{5'h10, 5'h04, 5'h02, 5'h01, 5'h0, 5'h0, 5'h0,
        5'h0, 5'h08, 5'h02, 5'h0, 5'h0, 5'h0, 5'h0};
    localparam logic [1:0] EVF [14] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h1, 2'h0,
        2'h0, 2'h0, 2'h2, 2'h0, 2'h1, 2'h0};
    ett_timer dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .frame_ev_i(frame_ev_i), .outside_field_i(outside_field_i),
        .own_field_i(own_field_i), .count_o(count_o), .running_o(running_o),
        .expired_o(expired_o), .guard_cfg_o(guard_cfg_o));
    // Clock generator
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        rd_val = rdata_o;
    endtask
    // Count cycles until the count moves, bounded
    task automatic wchg(output int k);
        logic [19:0] c0;
        c0 = count_o;
        k = 0;
        while (count_o === c0 && k < 3000) begin
            @(posedge clk_i);
            #1;
            k++;
        end
    endtask
    // Wait for the expiry pulse, bounded
    task automatic wexp;
        for (int k = 0; k < 100 && expired_o !== 1'b1; k++) begin
            @(posedge clk_i);
            #1;
        end
    endtask
    task automatic t_reset;
        #1;
        chk("idle_out", {11'h0, running_o, count_o}, 32'h0);
        chk("guard_rst", {3'h0, guard_cfg_o}, 32'h0);
        rd(8'h10);
        chk("cfg_rst", rd_val, 32'h0);
        rd(8'h11);
        chk("wait_rst", rd_val, 32'h0);
    endtask
    task automatic t_regs;
        wr(8'h10, 32'hffffffbe);
        rd(8'h10);
        chk("cfg_rw", rd_val, 32'h001fffbe);
        wr(8'h11, 32'hffffffff);
        rd(8'h11);
        chk("wait_rw", rd_val, 32'h0fffffff);
        chk("guard_on", {3'h0, guard_cfg_o}, 32'h1fffffff);
        wr(8'h11, 32'h7f);
        #1;
        chk("guard_off", {3'h0, guard_cfg_o}, 32'h000000fe);
        wr(8'h3f, 32'hffffffff);
        rd(8'h3f);
        chk("unmapped", rd_val, 32'h0);
        wr(8'h10, 32'h0);
    endtask
    task automatic t_expire;
        wr(8'h20, 32'h3);
        wr(8'h10, 32'h41);
        #1;
        chk("run_now", {11'h0, running_o, count_o}, {11'h0, 1'b1, 20'h3});
        wexp;
        chk("stop_zero", {10'h0, expired_o, running_o, count_o}, 32'h00200000);
        rd(8'h22);
        chk("sts_exp", rd_val, 32'h2);
        rd(8'h21);
        chk("cnt_rd", rd_val, 32'h0);
        wr(8'h22, 32'h2);
        rd(8'h22);
        chk("sts_clr", rd_val, 32'h0);
        wr(8'h10, 32'h43);
        wexp;
        chk("reload", {10'h0, expired_o, running_o, count_o}, 32'h00300003);
        wr(8'h10, 32'h40);
        #1;
        chk("off_idle", {31'h0, running_o}, 32'h0);
    endtask
    task automatic t_events;
        wr(8'h20, 32'h000fffff);
        for (int i = 0; i < 14; i++) begin
            wr(8'h10, 32'h0);
            wr(8'h10, {11'h0, EVC[i] | 21'h1});
            #1;
            chk("pre_event", {31'h0, running_o}, {31'h0, i >= 8});
            @(posedge clk_i);
            frame_ev_i <= EVE[i];
            {outside_field_i, own_field_i} <= EVF[i];
            @(posedge clk_i);
            frame_ev_i <= '0;
            repeat (4) @(posedge clk_i);
            #1;
            chk("event_run", {31'h0, running_o}, {31'h0, i < 8});
        end
    endtask
    task automatic t_rate;
        int k;
        int n;
        for (int s = 0; s < 9; s++) begin
            n = (s == 8) ? 1 : (2 << s);
            wr(8'h10, 32'h0);
            wr(8'h10, (s == 8) ? 32'h41 : (32'h45 | 32'(s << 3)));
            #1;
            wchg(k);
            wchg(k);
            chk("tick_gap", {31'h0, (k - n * 125000 / 13560) inside {[-2:2]}}, 32'h1);
        end
    endtask
    task automatic print_verdict;
        if (errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Watchdog against hangs
    initial begin
        #400000;
        errors++;
        print_verdict;
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset;
        t_regs;
        t_expire;
        t_events;
        t_rate;
        print_verdict;
    end
endmodule
`default_nettype wire
